// File: common/tcc_pkg.sv
// Shared constants and types of the timer capture and compare block.
package tcc_pkg;

  localparam logic [7:0]  ADDR_CONTROL          = 8'h12;
  localparam logic [7:0]  ADDR_STATUS           = 8'h13;
  localparam logic [7:0]  ADDR_CAPTURE_HIGH     = 8'h14;
  localparam logic [7:0]  ADDR_CAPTURE_LOW      = 8'h15;
  localparam logic [7:0]  ADDR_COMPARE_HIGH     = 8'h16;
  localparam logic [7:0]  ADDR_COMPARE_LOW      = 8'h17;
  localparam logic [7:0]  ADDR_COUNT_HIGH       = 8'h18;
  localparam logic [7:0]  ADDR_COUNT_LOW        = 8'h19;

  localparam int          BIT_CAPTURE_IRQ_EN    = 7;
  localparam int          BIT_COMPARE_IRQ_EN    = 6;
  localparam int          BIT_OVERFLOW_IRQ_EN   = 5;
  localparam int          BIT_EDGE_SELECT       = 1;
  localparam int          BIT_OUTPUT_LEVEL      = 0;
  localparam logic [7:0]  CONTROL_WRITE_MASK    = 8'hE3;
  localparam logic [7:0]  CONTROL_RESET         = 8'h00;

  localparam logic [7:0]  STATUS_CAPTURE_MASK   = 8'h80;
  localparam logic [7:0]  STATUS_COMPARE_MASK   = 8'h40;
  localparam logic [7:0]  STATUS_OVERFLOW_MASK  = 8'h20;
  localparam logic [7:0]  READ_IDLE             = 8'h00;

  localparam logic [15:0] COUNT_RESET           = 16'hFFFC;
  localparam logic [15:0] COUNT_WRAP            = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP            = 16'h0001;
  localparam logic [15:0] CAPTURE_OFFSET        = 16'h0001;

  typedef enum logic [1:0] {PH_T00, PH_T01, PH_T10, PH_T11} phase_t;

endpackage

// File: hw/capture_sync.sv
// Capture pin synchroniser, glitch filter and edge selector.
`timescale 1ns/1ps
`default_nettype none
module capture_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic capture_input_pin,
  input  wire logic capture_edge_select,
  output logic      capture_event
);

  logic sync_first;
  logic sync_second;
  logic sync_third;
  logic filtered_level;

  wire  agree    = (sync_second == sync_third);
  wire  changed  = agree && (sync_third != filtered_level);
  // [R21] edge polarity select.
  wire  edge_hit = changed && (sync_third == capture_edge_select);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_first     <= 1'b0;
      sync_second    <= 1'b0;
      sync_third     <= 1'b0;
      filtered_level <= 1'b0;
      capture_event  <= 1'b0;
    end else begin
      sync_first     <= capture_input_pin;
      sync_second    <= sync_first;
      sync_third     <= sync_second;
      filtered_level <= agree ? sync_third : filtered_level;
      capture_event  <= edge_hit;
    end
  end

  // [R21] edge polarity check.
  property p_edge_polarity;
    @(posedge ref_clk) disable iff (!rst_n)
    capture_event |-> (filtered_level == $past(capture_edge_select));
  endproperty
  a_edge_polarity: assert property (p_edge_polarity) else $error("capture edge of wrong polarity"); // [R21]

endmodule
`default_nettype wire

// File: hw/timer_capture_compare.sv
// Input capture and output compare logic of the 16-bit timer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] Valid edge copies counter into capture bytes.
// [R2] Captured value is counter plus one.
// [R3] Counter advances every four bus clocks.
// [R4] Every valid edge overwrites capture value; the code drops edges during a high-byte hold and frozen edges after the first.
// [R5] High byte read holds capture until low; a wake from freeze still loads the armed value.
// [R6] Reset keeps capture value contents.
// [R7] Match sets compare flag, drives level.
// [R8] Compare flag raises enabled interrupt request.
// [R9] High byte write blocks compare until low.
// [R10] Compare bytes independent, untouched by hardware.
// [R11] Level transfers on every match.
// [R12] Software initialises compare in safe order.
// [R13] Halt keeps counting; reset forces start.
// [R14] Freeze stops counter; reset forces start.
// [R15] Freeze edge arms, reports on wake.
// [R16] Reset touches counter, control and flags, not capture or compare.
// [R17] Capture flag sets in following T11.
// [R18] Compare evaluated only in phase T01.
// [R19] Compare flag sets in following T11.
// [R20] Overflow flag at wrap, status-then-low clear.
// [R21] Edge select chooses rising or falling.
// [R22] Capture flag clears: status, low read.
// [R23] Compare flag clears: status, low access.
// [R24] Capture flag raises enabled interrupt request.
// [R25] Counter unit supplies count and phase.
module timer_capture_compare (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_strobe,
  input  wire logic       rd_strobe,
  output logic [7:0]      rdata,
  input  wire logic       capture_input_pin,
  input  wire logic       freeze_mode,
  output logic            compare_output_pin,
  output logic            capture_flag,
  output logic            compare_flag,
  output logic            overflow_flag,
  output logic            capture_irq,
  output logic            compare_irq,
  output logic            overflow_irq
);

  logic [15:0]     count;
  tcc_pkg::phase_t phase;
  logic            capture_event;

  logic [7:0]      control;
  logic [15:0]     capture_value;
  logic [15:0]     compare_value;
  logic [15:0]     armed_value;
  logic            capture_hold;
  logic            compare_hold;
  logic            capture_pending;
  logic            match_pending;
  logic            freeze_seen;
  logic            armed;
  logic            capture_clear_armed;
  logic            compare_clear_armed;
  logic            overflow_clear_armed;

  // [R25] count and phase source.
  timer_counter u_counter (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .freeze_mode (freeze_mode),
    .count       (count),
    .phase       (phase)
  );

  capture_sync u_sync (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .capture_input_pin   (capture_input_pin),
    .capture_edge_select (control[tcc_pkg::BIT_EDGE_SELECT]),
    .capture_event       (capture_event)
  );

  // Register decode.
  wire wr_control      = wr_strobe && (addr == tcc_pkg::ADDR_CONTROL);
  wire wr_compare_high = wr_strobe && (addr == tcc_pkg::ADDR_COMPARE_HIGH);
  wire wr_compare_low  = wr_strobe && (addr == tcc_pkg::ADDR_COMPARE_LOW);
  wire rd_status       = rd_strobe && (addr == tcc_pkg::ADDR_STATUS);
  wire rd_capture_high = rd_strobe && (addr == tcc_pkg::ADDR_CAPTURE_HIGH);
  wire rd_capture_low  = rd_strobe && (addr == tcc_pkg::ADDR_CAPTURE_LOW);
  wire rd_compare_low  = rd_strobe && (addr == tcc_pkg::ADDR_COMPARE_LOW);
  wire rd_count_low    = rd_strobe && (addr == tcc_pkg::ADDR_COUNT_LOW);

  wire capture_irq_enable  = control[tcc_pkg::BIT_CAPTURE_IRQ_EN];
  wire compare_irq_enable  = control[tcc_pkg::BIT_COMPARE_IRQ_EN];
  wire overflow_irq_enable = control[tcc_pkg::BIT_OVERFLOW_IRQ_EN];
  wire compare_output_level = control[tcc_pkg::BIT_OUTPUT_LEVEL];

  // Flag sets happen only while the timer clocks run.
  wire flag_tick    = (phase == tcc_pkg::PH_T11) && !freeze_mode;
  wire compare_tick = (phase == tcc_pkg::PH_T01) && !freeze_mode;
  wire wake         = freeze_seen && !freeze_mode;

  // [R2] synchroniser offset of one count.
  wire [15:0] capture_sample = count + tcc_pkg::CAPTURE_OFFSET;

  // [R5] low byte read releases the hold in the same cycle.
  wire capture_transfer = capture_event && !freeze_mode && (!capture_hold || rd_capture_low);
  // [R15] only the first frozen edge is kept.
  wire arm_load         = capture_event && freeze_mode && !armed;
  wire arm_apply        = wake && armed;

  // [R18] compare only at T01 and only when not held.
  wire match_now        = !compare_hold && (count == compare_value);
  wire compare_hit      = match_pending && flag_tick;

  // [R17] pending edge reported at next T11.
  wire next_capture_pending = (capture_event && !freeze_mode) || (capture_pending && !flag_tick);
  wire next_match_pending   = compare_tick ? match_now : (match_pending && !flag_tick);
  wire next_armed           = arm_load || (armed && !wake);
  wire next_capture_hold    = rd_capture_high || (capture_hold && !rd_capture_low);
  // [R9] high write holds compare.
  wire next_compare_hold    = wr_compare_high || (compare_hold && !wr_compare_low);

  // [R22] status read then capture low read.
  wire capture_clear = capture_clear_armed && rd_capture_low;
  // [R23] status read then compare low access.
  wire compare_clear = compare_clear_armed && (rd_compare_low || wr_compare_low);
  // [R20] status read then counter low read.
  wire overflow_clear = overflow_clear_armed && rd_count_low;

  // [R17] capture flag set sources.
  wire capture_set  = (capture_pending && flag_tick) || arm_apply;
  // [R19] compare flag at T11 after match.
  wire compare_set  = compare_hit;
  // [R20] overflow flag at wrap in T11.
  wire overflow_set = flag_tick && (count == tcc_pkg::COUNT_WRAP);

  // A set in the same cycle as its clear wins, so no event is lost.
  wire next_capture_flag  = capture_set || (capture_flag && !capture_clear);
  wire next_compare_flag  = compare_set || (compare_flag && !compare_clear);
  wire next_overflow_flag = overflow_set || (overflow_flag && !overflow_clear);

  wire next_capture_armed  = (rd_status && capture_flag) || (capture_clear_armed && !capture_clear);
  wire next_compare_armed  = (rd_status && compare_flag) || (compare_clear_armed && !compare_clear);
  wire next_overflow_armed = (rd_status && overflow_flag) || (overflow_clear_armed && !overflow_clear);

  wire [7:0] status_byte = (capture_flag  ? tcc_pkg::STATUS_CAPTURE_MASK  : tcc_pkg::READ_IDLE)
                         | (compare_flag  ? tcc_pkg::STATUS_COMPARE_MASK  : tcc_pkg::READ_IDLE)
                         | (overflow_flag ? tcc_pkg::STATUS_OVERFLOW_MASK : tcc_pkg::READ_IDLE);

  wire [7:0] read_mux =
    (addr == tcc_pkg::ADDR_CONTROL)      ? control :
    (addr == tcc_pkg::ADDR_STATUS)       ? status_byte :
    (addr == tcc_pkg::ADDR_CAPTURE_HIGH) ? capture_value[15:8] :
    (addr == tcc_pkg::ADDR_CAPTURE_LOW)  ? capture_value[7:0] :
    (addr == tcc_pkg::ADDR_COMPARE_HIGH) ? compare_value[15:8] :
    (addr == tcc_pkg::ADDR_COMPARE_LOW)  ? compare_value[7:0] :
    (addr == tcc_pkg::ADDR_COUNT_HIGH)   ? count[15:8] :
    (addr == tcc_pkg::ADDR_COUNT_LOW)    ? count[7:0] :
                                           tcc_pkg::READ_IDLE;

  // [R16] control register is reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= tcc_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      control <= wdata & tcc_pkg::CONTROL_WRITE_MASK;
    end
  end

  // [R6] data registers have no reset.
  // A reset while frozen clears armed, so the frozen edge is dropped and capture_value keeps its old contents.
  always_ff @(posedge ref_clk) begin
    // [R1] [R4] transfer on every valid edge unless held or frozen; the first frozen edge loads on wake.
    if (capture_transfer) begin
      capture_value <= capture_sample;
    end else if (arm_apply) begin
      capture_value <= armed_value;
    end
    if (arm_load) begin
      armed_value <= capture_sample;
    end
    // [R10] byte writes leave the other byte.
    if (wr_compare_high) begin
      compare_value[15:8] <= wdata;
    end
    if (wr_compare_low) begin
      compare_value[7:0] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_hold    <= 1'b0;
      compare_hold    <= 1'b0;
      capture_pending <= 1'b0;
      match_pending   <= 1'b0;
      freeze_seen     <= 1'b0;
      armed           <= 1'b0;
    end else begin
      capture_hold    <= next_capture_hold;
      compare_hold    <= next_compare_hold;
      capture_pending <= next_capture_pending;
      match_pending   <= next_match_pending;
      freeze_seen     <= freeze_mode;
      armed           <= next_armed;
    end
  end

  // Flags are cleared at reset so the interrupt lines start defined.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_flag         <= 1'b0;
      compare_flag         <= 1'b0;
      overflow_flag        <= 1'b0;
      capture_clear_armed  <= 1'b0;
      compare_clear_armed  <= 1'b0;
      overflow_clear_armed <= 1'b0;
    end else begin
      capture_flag         <= next_capture_flag;
      compare_flag         <= next_compare_flag;
      overflow_flag        <= next_overflow_flag;
      capture_clear_armed  <= next_capture_armed;
      compare_clear_armed  <= next_compare_armed;
      overflow_clear_armed <= next_overflow_armed;
    end
  end

  // [R7] [R11] level loaded on every match.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_output_pin <= 1'b0;
    end else if (compare_hit) begin
      compare_output_pin <= compare_output_level;
    end
  end

  // [R8] [R24] enabled interrupt requests.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_irq  <= 1'b0;
      compare_irq  <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      capture_irq  <= capture_flag && capture_irq_enable;
      compare_irq  <= compare_flag && compare_irq_enable;
      overflow_irq <= overflow_flag && overflow_irq_enable;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= tcc_pkg::READ_IDLE;
    end else begin
      rdata <= rd_strobe ? read_mux : tcc_pkg::READ_IDLE;
    end
  end

  // [R19] compare flag after match.
  property p_compare_flag_set;
    @(posedge ref_clk) disable iff (!rst_n)
    (match_pending && flag_tick) |=> compare_flag;
  endproperty
  a_compare_flag_set: assert property (p_compare_flag_set) else $error("compare flag not set at T11"); // [R19]

  // [R11] level reaches the pin.
  property p_level_transfer;
    @(posedge ref_clk) disable iff (!rst_n)
    compare_hit |=> (compare_output_pin == $past(compare_output_level));
  endproperty
  a_level_transfer: assert property (p_level_transfer) else $error("output level not transferred"); // [R11]

  // [R9] held compare never matches.
  property p_compare_held;
    @(posedge ref_clk) disable iff (!rst_n)
    (compare_tick && compare_hold) |=> !match_pending;
  endproperty
  a_compare_held: assert property (p_compare_held) else $error("compare matched while held"); // [R9]

  // [R5] held capture keeps its value except on a wake from freeze.
  property p_capture_held;
    @(posedge ref_clk) disable iff (!rst_n)
    (capture_hold && !rd_capture_low && !arm_apply) |=> $stable(capture_value);
  endproperty
  a_capture_held: assert property (p_capture_held) else $error("capture changed while held"); // [R5]

  // [R2] captured value is count plus one.
  property p_capture_value;
    @(posedge ref_clk) disable iff (!rst_n)
    capture_transfer |=> (capture_value == $past(count) + tcc_pkg::CAPTURE_OFFSET);
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("captured value wrong"); // [R2]

  // [R20] overflow flag at wrap.
  property p_overflow_set;
    @(posedge ref_clk) disable iff (!rst_n)
    (flag_tick && count == tcc_pkg::COUNT_WRAP) |=> overflow_flag;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("overflow flag not set at wrap"); // [R20]

  // [R22] capture flag falls only by the sequence.
  property p_capture_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(capture_flag) |-> $past(capture_clear_armed && rd_capture_low);
  endproperty
  a_capture_clear: assert property (p_capture_clear) else $error("capture flag cleared without sequence"); // [R22]

  // [R15] no capture flag raised while frozen.
  property p_freeze_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(capture_flag) |-> !$past(freeze_mode);
  endproperty
  a_freeze_quiet: assert property (p_freeze_quiet) else $error("capture flag set during freeze"); // [R15]

  // [R10] compare value changes only by writes.
  property p_compare_stable;
    @(posedge ref_clk) disable iff (!rst_n)
    !(wr_compare_high || wr_compare_low) |=> $stable(compare_value);
  endproperty
  a_compare_stable: assert property (p_compare_stable) else $error("compare value altered by hardware"); // [R10]

  // [R24] enabled capture flag requests an interrupt.
  property p_capture_irq;
    @(posedge ref_clk) disable iff (!rst_n)
    (capture_flag && capture_irq_enable) |=> capture_irq;
  endproperty
  a_capture_irq: assert property (p_capture_irq) else $error("capture interrupt not raised"); // [R24]

endmodule
`default_nettype wire

// File: hw/timer_counter.sv
// Free-running counter with its four-state timer phase.
`timescale 1ns/1ps
`default_nettype none
module timer_counter (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             freeze_mode,
  output logic [15:0]           count,
  output var tcc_pkg::phase_t   phase
);

  tcc_pkg::phase_t next_phase;
  logic [15:0]     next_count;

  always_comb begin
    unique case (phase)
      tcc_pkg::PH_T00: next_phase = tcc_pkg::PH_T01;
      tcc_pkg::PH_T01: next_phase = tcc_pkg::PH_T10;
      tcc_pkg::PH_T10: next_phase = tcc_pkg::PH_T11;
      tcc_pkg::PH_T11: next_phase = tcc_pkg::PH_T00;
    endcase
  end

  // [R3] one count per phase cycle.
  assign next_count = (phase == tcc_pkg::PH_T11) ? count + tcc_pkg::COUNT_STEP : count;

  // [R13] reset forces start value.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= tcc_pkg::COUNT_RESET;
      phase <= tcc_pkg::PH_T00;
    end else if (!freeze_mode) begin
      count <= next_count;
      phase <= next_phase;
    end
  end

  // [R3] counter advances after T11.
  property p_count_advance;
    @(posedge ref_clk) disable iff (!rst_n)
    (!freeze_mode && phase == tcc_pkg::PH_T11) |=> (count == $past(count) + tcc_pkg::COUNT_STEP);
  endproperty
  a_count_advance: assert property (p_count_advance) else $error("counter did not advance"); // [R3]

  // [R14] frozen counter holds.
  property p_count_frozen;
    @(posedge ref_clk) disable iff (!rst_n)
    (freeze_mode || phase != tcc_pkg::PH_T11) |=> $stable(count);
  endproperty
  a_count_frozen: assert property (p_count_frozen) else $error("counter moved outside T11 or in freeze"); // [R14]

endmodule
`default_nettype wire

// File: tb/pin_model.sv
// Model of the signal source on the capture pin and the load on the compare pin.
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic ref_clk,
  input  wire logic compare_output_pin,
  output var logic  capture_input_pin
);
  initial begin
    capture_input_pin = 1'b0;
  end
  // Levels change away from the sampling edge and stay long enough to pass the filter.
  task drive(input logic v);
    @(negedge ref_clk);
    capture_input_pin = v;
    repeat (8) @(posedge ref_clk);
    // Hand control back off the edge, so the caller never samples a flag in the step that launches it.
    #1;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the timer capture and compare block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr_strobe;
  logic        rd_strobe;
  logic        freeze_mode;
  wire logic [7:0] rdata;
  wire logic   capture_input_pin;
  wire logic   compare_output_pin;
  wire logic   capture_flag;
  wire logic   compare_flag;
  wire logic   overflow_flag;
  wire logic   capture_irq;
  wire logic   compare_irq;
  wire logic   overflow_irq;
  int          errors;
  int          checks;
  logic [7:0]  b;
  logic [15:0] c0;
  logic [15:0] cap;
  logic [15:0] cap2;
  logic [15:0] t;
  row_t        rows [12];

  timer_capture_compare dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .capture_input_pin(capture_input_pin),
    .freeze_mode(freeze_mode), .compare_output_pin(compare_output_pin), .capture_flag(capture_flag),
    .compare_flag(compare_flag), .overflow_flag(overflow_flag), .capture_irq(capture_irq),
    .compare_irq(compare_irq), .overflow_irq(overflow_irq));

  pin_model pins_u (.ref_clk(ref_clk), .compare_output_pin(compare_output_pin),
    .capture_input_pin(capture_input_pin));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_strobe <= 1'b1;
    addr      <= a;
    wdata     <= d;
    @(posedge ref_clk);
    wr_strobe <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd_strobe <= 1'b1;
    addr      <= a;
    @(posedge ref_clk);
    rd_strobe <= 1'b0;
    #1 d = rdata;
  endtask

  // High byte first, so a capture read holds the pair together.
  task rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(a, h);
    rd(a + 8'h01, l);
    v = {h, l};
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: pick = overflow_flag;
      1: pick = capture_flag;
      2: pick = compare_flag;
      default: pick = compare_output_pin;
    endcase
  endfunction

  task wait_for(input int w, input logic v, input int lim);
    for (int i = 0; i < lim && pick(w) !== v; i++) cyc(1);
    chk("wait", {15'h0000, pick(w)}, {15'h0000, v});
    if (pick(w) !== v) summarize();
  endtask

  initial begin
    rst_n       = 1'b0;
    addr        = 8'h00;
    wdata       = 8'h00;
    wr_strobe   = 1'b0;
    rd_strobe   = 1'b0;
    freeze_mode = 1'b0;
    errors      = 0;
    checks      = 0;
    rows = '{'{1'b0, 8'h12, 8'h00, 8'h20}, '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b1, 8'h16, 8'hA5, 8'h00},
             '{1'b1, 8'h17, 8'h3C, 8'h00}, '{1'b0, 8'h16, 8'h00, 8'hA5}, '{1'b0, 8'h17, 8'h00, 8'h3C},
             '{1'b1, 8'h17, 8'h5A, 8'h00}, '{1'b0, 8'h16, 8'h00, 8'hA5}, '{1'b0, 8'h17, 8'h00, 8'h5A},
             '{1'b1, 8'h12, 8'hFF, 8'h00}, '{1'b0, 8'h12, 8'h00, 8'hE3}, '{1'b1, 8'h12, 8'h00, 8'h00}};
    // The compare register has no reset, so it gets a known value that the run never reaches while reset is held.
    // An unknown value would make the compare flag unknown for the rest of the run.
    wr(tcc_pkg::ADDR_COMPARE_HIGH, 8'h80);
    wr(tcc_pkg::ADDR_COMPARE_LOW, 8'h00);
    cyc(1);
    rst_n <= 1'b1;
    wr(tcc_pkg::ADDR_CONTROL, 8'h20);
    // Counter starts just below the wrap, so the overflow flag comes soon after reset.
    wait_for(0, 1'b1, 40);
    cyc(1);
    chk("ovf_irq", {15'h0000, overflow_irq}, 16'h0001);
    rd(tcc_pkg::ADDR_STATUS, b);
    chk("ovf_status", {8'h00, b & tcc_pkg::STATUS_OVERFLOW_MASK}, 16'h0020);
    rd(tcc_pkg::ADDR_COUNT_LOW, b);
    cyc(2);
    chk("ovf_clear", {14'h0000, overflow_flag, overflow_irq}, 16'h0000);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, b);
        chk("table", {8'h00, b}, {8'h00, rows[i].e});
      end
    end
    wr(tcc_pkg::ADDR_CONTROL, 8'h82);
    rd16(tcc_pkg::ADDR_COUNT_HIGH, c0);
    pins_u.drive(1'b1);
    wait_for(1, 1'b1, 20);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, cap);
    chk("cap_delta", {15'h0000, (cap - c0) >= 16'h0001 && (cap - c0) <= 16'h0008}, 16'h0001);
    chk("cap_irq", {15'h0000, capture_irq}, 16'h0001);
    rd(tcc_pkg::ADDR_CAPTURE_HIGH, b);
    pins_u.drive(1'b0);
    pins_u.drive(1'b1);
    rd(tcc_pkg::ADDR_CAPTURE_LOW, b);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, cap2);
    chk("cap_held", cap2, cap);
    pins_u.drive(1'b0);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, cap2);
    chk("cap_fall", cap2, cap);
    pins_u.drive(1'b1);
    cyc(8);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, cap2);
    chk("cap_new", {15'h0000, cap2 !== cap}, 16'h0001);
    rd(tcc_pkg::ADDR_STATUS, b);
    chk("cap_status", {8'h00, b & tcc_pkg::STATUS_CAPTURE_MASK}, 16'h0080);
    rd(tcc_pkg::ADDR_CAPTURE_LOW, b);
    cyc(3);
    chk("cap_clear", {14'h0000, capture_flag, capture_irq}, 16'h0000);
    wr(tcc_pkg::ADDR_CONTROL, 8'h41);
    rd16(tcc_pkg::ADDR_COUNT_HIGH, c0);
    t = c0 + 16'h0008;
    wr(tcc_pkg::ADDR_COMPARE_LOW, t[7:0]);
    wr(tcc_pkg::ADDR_COMPARE_HIGH, t[15:8]);
    cyc(60);
    chk("cmp_held", {15'h0000, compare_flag}, 16'h0000);
    rd16(tcc_pkg::ADDR_COUNT_HIGH, c0);
    t = c0 + 16'h0008;
    wr(tcc_pkg::ADDR_COMPARE_HIGH, t[15:8]);
    rd(tcc_pkg::ADDR_STATUS, b);
    wr(tcc_pkg::ADDR_COMPARE_LOW, t[7:0]);
    wait_for(2, 1'b1, 60);
    chk("cmp_pin", {15'h0000, compare_output_pin}, 16'h0001);
    cyc(2);
    chk("cmp_irq", {15'h0000, compare_irq}, 16'h0001);
    wr(tcc_pkg::ADDR_CONTROL, 8'h40);
    rd16(tcc_pkg::ADDR_COUNT_HIGH, c0);
    t = c0 + 16'h0008;
    wr(tcc_pkg::ADDR_COMPARE_HIGH, t[15:8]);
    wr(tcc_pkg::ADDR_COMPARE_LOW, t[7:0]);
    wait_for(3, 1'b0, 60);
    rd(tcc_pkg::ADDR_STATUS, b);
    rd(tcc_pkg::ADDR_COMPARE_LOW, b);
    cyc(2);
    chk("cmp_clear", {15'h0000, compare_flag}, 16'h0000);
    wr(tcc_pkg::ADDR_CONTROL, 8'h82);
    @(posedge ref_clk);
    freeze_mode <= 1'b1;
    cyc(2);
    rd16(tcc_pkg::ADDR_COUNT_HIGH, c0);
    pins_u.drive(1'b0);
    pins_u.drive(1'b1);
    rd16(tcc_pkg::ADDR_COUNT_HIGH, cap);
    chk("frz_count", cap, c0);
    chk("frz_flag", {15'h0000, capture_flag}, 16'h0000);
    @(posedge ref_clk);
    freeze_mode <= 1'b0;
    wait_for(1, 1'b1, 20);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, cap);
    chk("frz_cap", cap, c0 + 16'h0001);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rd(tcc_pkg::ADDR_COUNT_HIGH, b);
    chk("rst_count", {8'h00, b}, 16'h00FF);
    rd16(tcc_pkg::ADDR_CAPTURE_HIGH, cap2);
    chk("rst_cap", cap2, cap);
    rd16(tcc_pkg::ADDR_COMPARE_HIGH, c0);
    chk("rst_cmp", c0, t);
    rd(tcc_pkg::ADDR_CONTROL, b);
    chk("rst_ctrl", {8'h00, b}, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
